// ==== src/hbm_pkg.sv ====
package hbm_pkg;

  localparam int          HADDR_W      = 5;
  localparam logic [1:0]  MODE_ISA     = 2'h0;
  localparam logic [1:0]  MODE_SPLIT   = 2'h1;
  localparam logic [1:0]  MODE_MCU     = 2'h2;
  localparam logic [4:0]  DATA_PORT_ADDR = 5'h10;
  localparam logic [1:0]  BE_EVEN      = 2'h1;
  localparam logic [1:0]  BE_ODD       = 2'h2;
  localparam logic [1:0]  BE_WORD      = 2'h3;
  localparam logic [4:0]  MGMT_PHY_ADDR = 5'h10;
  localparam logic [4:0]  PHY_STATUS_REG = 5'h01;
  localparam logic [15:0] NOPRE_MASK   = 16'h0040;
  localparam logic [1:0]  OP_RD        = 2'h2;
  localparam logic [1:0]  OP_WR        = 2'h1;
  localparam logic [3:0]  OP_LAST      = 4'h1;
  localparam logic [3:0]  ADDR_LAST    = 4'h9;
  localparam logic [3:0]  TA_LAST      = 4'h1;
  localparam logic [3:0]  DATA_LAST    = 4'hF;
  localparam int          CLK_KHZ      = 10000;
  localparam int          MDC_MAX_KHZ  = 2500;
  localparam int          MDC_MIN_CYC  = CLK_KHZ / MDC_MAX_KHZ;
  localparam int          SYNC_MIN_CYC = 4;

  typedef struct packed {
    logic [HADDR_W-1:0] addr;
    logic [1:0]         be;
    logic [15:0]        wdata;
  } hbm_hacc_t;

  typedef struct packed {
    logic [4:0]  regad;
    logic [15:0] wdata;
  } hbm_macc_t;

  typedef enum logic [5:0] {
    MS_IDLE  = 6'h01,
    MS_START = 6'h02,
    MS_OPC   = 6'h04,
    MS_ADDR  = 6'h08,
    MS_TURN  = 6'h10,
    MS_DATA  = 6'h20
  } hbm_mst_t;
endpackage

// ==== src/hbm_top.sv ====
`timescale 1ns/1ps
module hbm_top #(
  parameter logic [4:0] PHY_ADDR = hbm_pkg::MGMT_PHY_ADDR
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [1:0]             bus_mode,
  input  wire logic                   chip_select_n,
  input  wire logic                   aen,
  input  wire logic                   program_store_enable,
  input  wire logic                   read_strobe_n,
  input  wire logic                   write_strobe_n,
  input  wire logic                   byte_select_addr_bit,
  input  wire logic [4:0]             host_addr,
  input  wire logic                   word_transfer_select,
  input  wire logic [15:0]            host_data_bus_in,
  output logic      [15:0]            host_data_bus_out,
  output logic      [1:0]             host_data_bus_oe_n,
  input  wire logic [15:0]            acc_rdata,
  output hbm_pkg::hbm_hacc_t          acc_req,
  output logic                        acc_rd,
  output logic                        acc_wr,
  input  wire logic                   mdc,
  input  wire logic                   mdio_in,
  output logic                        mdio_out,
  output logic                        mdio_oe_n,
  input  wire logic [15:0]            mgmt_rdata,
  output hbm_pkg::hbm_macc_t          mgmt_req,
  output logic                        mgmt_rd,
  output logic                        mgmt_wr
);

  // edge finding needs two clocks per mdc half period
  if (hbm_pkg::MDC_MIN_CYC < hbm_pkg::SYNC_MIN_CYC) begin : g_chk
    $error("mclk too slow for the fastest mdc");
  end
  // every host and mdio pin passes two flip-flops; only stage two is read
  logic [31:0] pin_c;
  logic [31:0] sync1_reg;
  logic [31:0] sync2_reg;
  assign pin_c = {bus_mode, chip_select_n, aen, program_store_enable,
                  read_strobe_n, write_strobe_n, byte_select_addr_bit,
                  host_addr, word_transfer_select, host_data_bus_in,
                  mdc, mdio_in};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 32'h0000_0000;
      sync2_reg <= 32'h0000_0000;
    end else begin
      sync1_reg <= pin_c;
      sync2_reg <= sync1_reg;
    end
  end
  logic [1:0]  s_mode;
  logic        s_cs_n, s_aen, s_pse, s_rd_n, s_wr_n, s_bsel, s_wsel;
  logic [4:0]  s_addr;
  logic [15:0] s_data;
  logic        s_mdc, s_mdio;
  assign {s_mode, s_cs_n, s_aen, s_pse, s_rd_n, s_wr_n, s_bsel, s_addr,
          s_wsel, s_data, s_mdc, s_mdio} = sync2_reg;
  // host cycle decode
  logic sel_c, word_c, rd_c, wr_c;
  always_comb begin
    case (s_mode)
      hbm_pkg::MODE_ISA:   sel_c = !s_cs_n && !s_aen;
      hbm_pkg::MODE_MCU:   sel_c = !s_cs_n && s_pse;
      default:             sel_c = !s_cs_n;
    endcase
    word_c = s_mode != hbm_pkg::MODE_MCU && s_wsel && !s_bsel
             && s_addr == hbm_pkg::DATA_PORT_ADDR;
    rd_c = sel_c && !s_rd_n && s_wr_n;
    wr_c = sel_c && !s_wr_n && s_rd_n;
  end
  logic [15:0]        dout_reg, dout_next;
  logic [1:0]         doe_reg, doe_next;
  hbm_pkg::hbm_hacc_t acc_reg, acc_next;
  logic               rdact_reg, rdact_next, wract_reg, wract_next;
  logic               accrd_reg, accrd_next, accwr_reg, accwr_next;
  // host lane steering; write commits when the strobe goes away
  always_comb begin
    dout_next  = dout_reg;
    doe_next   = 2'h3;
    acc_next   = acc_reg;
    rdact_next = rd_c;
    wract_next = wr_c;
    accrd_next = rd_c && !rdact_reg;
    accwr_next = !wr_c && wract_reg;
    if (rd_c) begin
      doe_next      = 2'h0;
      // odd byte stays on the upper lane
      dout_next[15:8] = acc_rdata[15:8];
      // odd byte folded to the low lane
      if (s_bsel && s_mode != hbm_pkg::MODE_SPLIT) begin
        dout_next[7:0] = acc_rdata[15:8];
      end else begin
        dout_next[7:0] = acc_rdata[7:0];
      end
    end
    // reads carry index and lanes too; a word read drains two bytes
    if (rd_c || wr_c) begin
      acc_next.addr = s_addr;
      if (word_c) begin
        acc_next.be = hbm_pkg::BE_WORD;
      end else if (s_bsel) begin
        acc_next.be = hbm_pkg::BE_ODD;
      end else begin
        acc_next.be = hbm_pkg::BE_EVEN;
      end
    end
    if (wr_c) begin
      // split lanes used as they stand
      if (word_c || s_mode == hbm_pkg::MODE_SPLIT) begin
        acc_next.wdata = s_data;
      end else begin
        // byte comes from the low lane
        acc_next.wdata = {s_data[7:0], s_data[7:0]};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout_reg  <= 16'h0000;
      doe_reg   <= 2'h3;
      acc_reg   <= '0;
      rdact_reg <= 1'b0;
      wract_reg <= 1'b0;
      accrd_reg <= 1'b0;
      accwr_reg <= 1'b0;
    end else begin
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      acc_reg   <= acc_next;
      rdact_reg <= rdact_next;
      wract_reg <= wract_next;
      accrd_reg <= accrd_next;
      accwr_reg <= accwr_next;
    end
  end

  assign host_data_bus_out  = dout_reg;
  assign host_data_bus_oe_n = doe_reg;
  assign acc_req            = acc_reg;
  assign acc_rd             = accrd_reg;
  assign acc_wr             = accwr_reg;
  // mdc edges from the synchronised level
  logic mdc_d_reg, rise_c, fall_c;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mdc_d_reg <= 1'b0;
    end else begin
      mdc_d_reg <= s_mdc;
    end
  end
  // sample on rise, drive on fall
  assign rise_c = s_mdc && !mdc_d_reg;
  assign fall_c = !s_mdc && mdc_d_reg;
  hbm_pkg::hbm_mst_t  mst_reg, mst_next;
  logic [3:0]         cnt_reg, cnt_next;
  logic [15:0]        sh_reg, sh_next;
  logic [1:0]         op_reg, op_next;
  logic               mine_reg, mine_next;
  hbm_pkg::hbm_macc_t mreq_reg, mreq_next;
  logic               mrd_reg, mrd_next, mwr_reg, mwr_next;
  logic               mo_reg, mo_next, moe_reg, moe_next;
  logic [9:0]         adr_c;
  logic               rdown_c;
  // management frame receiver and read driver
  always_comb begin
    mst_next  = mst_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    op_next   = op_reg;
    mine_next = mine_reg;
    mreq_next = mreq_reg;
    mrd_next  = 1'b0;
    mwr_next  = 1'b0;
    mo_next   = mo_reg;
    moe_next  = moe_reg;
    adr_c     = {sh_reg[8:0], s_mdio};
    rdown_c   = mine_reg && op_reg == hbm_pkg::OP_RD;
    if (rise_c) begin
      cnt_next = cnt_reg + 4'h1;
      case (mst_reg)
        // ones are optional preamble, zero opens start
        hbm_pkg::MS_IDLE: begin
          if (!s_mdio) begin
            mst_next = hbm_pkg::MS_START;
          end
        end
        hbm_pkg::MS_START: begin
          cnt_next = 4'h0;
          mst_next = s_mdio ? hbm_pkg::MS_OPC : hbm_pkg::MS_IDLE;
        end
        hbm_pkg::MS_OPC: begin
          op_next = {op_reg[0], s_mdio};
          if (cnt_reg == hbm_pkg::OP_LAST) begin
            cnt_next = 4'h0;
            mst_next = hbm_pkg::MS_ADDR;
          end
        end
        hbm_pkg::MS_ADDR: begin
          sh_next = {sh_reg[14:0], s_mdio};
          if (cnt_reg == hbm_pkg::ADDR_LAST) begin
            cnt_next = 4'h0;
            mst_next = hbm_pkg::MS_TURN;
            mreq_next.regad = adr_c[4:0];
            // only own address and known opcodes
            mine_next = adr_c[9:5] == PHY_ADDR &&
                        (op_reg == hbm_pkg::OP_RD ||
                         op_reg == hbm_pkg::OP_WR);
            mrd_next = mine_next && op_reg == hbm_pkg::OP_RD;
          end
        end
        hbm_pkg::MS_TURN: begin
          if (cnt_reg == 4'h0 && rdown_c) begin
            sh_next = mgmt_rdata;
            if (mreq_reg.regad == hbm_pkg::PHY_STATUS_REG) begin
              sh_next = mgmt_rdata | hbm_pkg::NOPRE_MASK;
            end
          end
          if (cnt_reg == hbm_pkg::TA_LAST) begin
            cnt_next = 4'h0;
            mst_next = hbm_pkg::MS_DATA;
          end
        end
        hbm_pkg::MS_DATA: begin
          // one register shifts out reads and in writes
          sh_next = {sh_reg[14:0], s_mdio};
          if (cnt_reg == hbm_pkg::DATA_LAST) begin
            mst_next = hbm_pkg::MS_IDLE;
            mine_next = 1'b0;
            if (mine_reg && op_reg == hbm_pkg::OP_WR) begin
              mwr_next = 1'b1;
              mreq_next.wdata = {sh_reg[14:0], s_mdio};
            end
          end
        end
        default: begin
          mst_next = hbm_pkg::MS_IDLE;
        end
      endcase
    end
    if (fall_c) begin
      // drive only turnaround bit two and data
      if (rdown_c && mst_reg == hbm_pkg::MS_TURN &&
          cnt_reg == hbm_pkg::TA_LAST) begin
        moe_next = 1'b0;
        mo_next  = 1'b0;
      end else if (rdown_c && mst_reg == hbm_pkg::MS_DATA) begin
        moe_next = 1'b0;
        mo_next  = sh_reg[15];
      end else begin
        moe_next = 1'b1;
        mo_next  = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mst_reg  <= hbm_pkg::MS_IDLE;
      cnt_reg  <= 4'h0;
      sh_reg   <= 16'h0000;
      op_reg   <= 2'h0;
      mine_reg <= 1'b0;
      mreq_reg <= '0;
      mrd_reg  <= 1'b0;
      mwr_reg  <= 1'b0;
      mo_reg   <= 1'b1;
      moe_reg  <= 1'b1;
    end else begin
      mst_reg  <= mst_next;
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      op_reg   <= op_next;
      mine_reg <= mine_next;
      mreq_reg <= mreq_next;
      mrd_reg  <= mrd_next;
      mwr_reg  <= mwr_next;
      mo_reg   <= mo_next;
      moe_reg  <= moe_next;
    end
  end

  assign mdio_out  = mo_reg;
  assign mdio_oe_n = moe_reg;
  assign mgmt_req  = mreq_reg;
  assign mgmt_rd   = mrd_reg;
  assign mgmt_wr   = mwr_reg;
  // checks on what this block drives
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  standby_lanes_off_a: assert property (!sel_c |=> doe_reg == 2'h3)
    else $error("lanes driven in standby");
  mcu_store_off_a: assert property (
    s_mode == hbm_pkg::MODE_MCU && !s_pse |=> doe_reg == 2'h3)
    else $error("mcu lanes driven with store enable low");
  isa_odd_low_a: assert property (
    rd_c && s_bsel && s_mode == hbm_pkg::MODE_ISA
    |=> dout_reg[7:0] == $past(acc_rdata[15:8]) && doe_reg == 2'h0)
    else $error("isa odd byte not on low lane");
  split_odd_hi_a: assert property (
    rd_c && s_bsel && s_mode == hbm_pkg::MODE_SPLIT
    |=> dout_reg[15:8] == $past(acc_rdata[15:8]))
    else $error("split odd byte not on upper lane");
  mcu_no_word_a: assert property (
    accwr_reg && $past(s_mode, 2) == hbm_pkg::MODE_MCU
    && $past(s_mode) == hbm_pkg::MODE_MCU |-> acc_reg.be != 2'h3)
    else $error("word write in mcu mode");
  phy_match_a: assert property (
    mrd_reg |-> $past(adr_c[9:5]) == PHY_ADDR)
    else $error("read taken for another phy");
  ta_drive_zero_a: assert property (
    $fell(moe_reg) |-> !mo_reg && mst_reg == hbm_pkg::MS_TURN)
    else $error("turnaround not driven low");
  idle_release_a: assert property (
    rise_c && mst_reg == hbm_pkg::MS_IDLE |-> moe_reg)
    else $error("mdio driven while idle");
  write_opcode_a: assert property (
    mwr_reg |-> op_reg == hbm_pkg::OP_WR && mst_reg == hbm_pkg::MS_IDLE)
    else $error("write pulse without write opcode");
  status_nopre_a: assert property (
    rise_c && mst_reg == hbm_pkg::MS_TURN && cnt_reg == 4'h0 && rdown_c
    && mreq_reg.regad == hbm_pkg::PHY_STATUS_REG |=> sh_reg[6])
    else $error("status bit six not set");

  isa_read_c: cover property (rd_c && s_mode == hbm_pkg::MODE_ISA ##1 1);
  split_write_c: cover property (
    wr_c && s_mode == hbm_pkg::MODE_SPLIT ##[1:20] accwr_reg);
  mgmt_read_c: cover property (mrd_reg ##[1:300] $fell(moe_reg));
  mgmt_write_c: cover property (mwr_reg);
endmodule

// ==== bench/hbm_mgmt_station.sv ====
`timescale 1ns/1ps
// station manager model; mdc stands low between frames so the
// device never sees a stray edge, and the line is left to the pull-up
module hbm_mgmt_station #(
  parameter int HALF_NS = 400
) (
  input  wire logic mdio_line,
  output logic      mdc,
  output logic      mdio_bit,
  output logic      mdio_oe_n
);
  initial begin
    mdc = 1'h0;
    mdio_bit = 1'h1;
    mdio_oe_n = 1'h1;
  end

  // one frame, no preamble; rd gets the second turnaround bit and
  // the data bits as seen on the line, plus one idle clock at the end
  // msb first, frame order
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [16:0] rd);
    logic [31:0] sh;
    int          n;
    sh = {2'h1, op, pa, ra, 2'h2, wd};
    n = (op == 2'h1) ? 32 : 14;
    rd = 17'h0;
    for (int i = 0; i < 33; i++) begin
      // change after fall, release when done
      mdio_oe_n = (i < n) ? 1'h0 : 1'h1;
      mdio_bit = (i < n) ? sh[31-i] : 1'h1;
      // half period keeps the rate legal
      #(HALF_NS) mdc = 1'h1;
      if (i >= 15 && i < 32)
        rd = {rd[15:0], mdio_line};
      #(HALF_NS) mdc = 1'h0;
    end
  endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin \
  n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module testbench;
  typedef struct packed {
    logic [1:0]  m;
    logic        bsel;
    logic        wsel;
    logic        wr;
    logic [4:0]  ad;
    logic [1:0]  be;
    logic [15:0] exp;
    logic [15:0] msk;
  } hbm_tb_row_t;
  typedef struct packed {
    logic [1:0]  op;
    logic [4:0]  pa;
    logic [4:0]  ra;
    logic [15:0] wd;
    logic [16:0] rd;
    logic [1:0]  pl;
  } hbm_tb_frm_t;

  // mode, odd byte, word select, write, index, lanes, expected, valid lanes
  localparam hbm_tb_row_t ROWS[16] = '{
    '{2'h0, 1'h0, 1'h0, 1'h0, 5'h03, 2'h1, 16'h0043, 16'h00FF},
    '{2'h0, 1'h1, 1'h0, 1'h0, 5'h03, 2'h2, 16'h00A3, 16'h00FF},
    '{2'h0, 1'h0, 1'h1, 1'h0, 5'h03, 2'h1, 16'h0043, 16'h00FF},
    '{2'h0, 1'h0, 1'h1, 1'h0, 5'h10, 2'h3, 16'hB050, 16'hFFFF},
    '{2'h1, 1'h0, 1'h0, 1'h0, 5'h04, 2'h1, 16'h0044, 16'h00FF},
    '{2'h1, 1'h1, 1'h0, 1'h0, 5'h03, 2'h2, 16'hA300, 16'hFF00},
    '{2'h1, 1'h0, 1'h1, 1'h0, 5'h10, 2'h3, 16'hB050, 16'hFFFF},
    '{2'h2, 1'h1, 1'h0, 1'h0, 5'h02, 2'h2, 16'h00A2, 16'h00FF},
    '{2'h2, 1'h0, 1'h1, 1'h0, 5'h10, 2'h1, 16'h0050, 16'h00FF},
    '{2'h0, 1'h0, 1'h0, 1'h1, 5'h05, 2'h1, 16'h00A5, 16'h00FF},
    '{2'h0, 1'h1, 1'h0, 1'h1, 5'h05, 2'h2, 16'hA500, 16'hFF00},
    '{2'h1, 1'h1, 1'h0, 1'h1, 5'h05, 2'h2, 16'hC300, 16'hFF00},
    '{2'h1, 1'h0, 1'h0, 1'h1, 5'h05, 2'h1, 16'h00A5, 16'h00FF},
    '{2'h0, 1'h0, 1'h1, 1'h1, 5'h10, 2'h3, 16'hC3A5, 16'hFFFF},
    '{2'h2, 1'h1, 1'h1, 1'h1, 5'h10, 2'h2, 16'hA500, 16'hFF00},
    '{2'h0, 1'h1, 1'h1, 1'h1, 5'h10, 2'h2, 16'hA500, 16'hFF00}};
  // opcode, phy, register, write data, line seen, pulses expected
  localparam hbm_tb_frm_t FRMS[7] = '{
    '{2'h1, 5'h10, 5'h1F, 16'h8001, 17'h08001, 2'h1},
    '{2'h2, 5'h10, 5'h02, 16'h0000, 17'h01081, 2'h1},
    '{2'h2, 5'h10, 5'h01, 16'h0000, 17'h008C1, 2'h1},
    '{2'h2, 5'h0F, 5'h02, 16'h0000, 17'h1FFFF, 2'h0},
    '{2'h1, 5'h0F, 5'h03, 16'h1234, 17'h01234, 2'h0},
    '{2'h0, 5'h10, 5'h02, 16'h0000, 17'h1FFFF, 2'h0},
    '{2'h3, 5'h10, 5'h02, 16'h0000, 17'h1FFFF, 2'h0}};

  logic               mclk, rst, cs_n, aen, pse, rd_n, wr_n, bsel, wsel;
  logic [1:0]         mode, oe_n;
  logic [4:0]         haddr;
  logic [15:0]        hdin, hdout, acc_rdata, mgmt_rdata;
  logic [16:0]        got;
  hbm_pkg::hbm_hacc_t acc_req;
  hbm_pkg::hbm_macc_t mgmt_req;
  logic               acc_rd, acc_wr, mgmt_rd, mgmt_wr, mdc, mdio_line;
  logic               mdio_out, mdio_oe_n, s_bit, s_oe_n;
  int                 n_mismatch, tests_run, p;
  int                 np = 0;

  // core contents are a pattern of the index so each byte is unique
  assign acc_rdata = {3'h5, acc_req.addr, 3'h2, acc_req.addr};
  assign mgmt_rdata = {mgmt_req.regad, 11'h081};
  // pull-up wins when neither party drives
  assign mdio_line = !mdio_oe_n ? mdio_out : (!s_oe_n ? s_bit : 1'h1);

  always #50 mclk = ~mclk;
  // every strobe toward the core is counted
  always @(posedge mclk) np <= np + acc_rd + acc_wr + mgmt_rd + mgmt_wr;

  hbm_top dut (.mclk(mclk), .rst(rst), .bus_mode(mode),
    .chip_select_n(cs_n), .aen(aen), .program_store_enable(pse),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .byte_select_addr_bit(bsel), .host_addr(haddr),
    .word_transfer_select(wsel), .host_data_bus_in(hdin),
    .host_data_bus_out(hdout), .host_data_bus_oe_n(oe_n),
    .acc_rdata(acc_rdata), .acc_req(acc_req), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .mdc(mdc), .mdio_in(mdio_line),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .mgmt_rdata(mgmt_rdata), .mgmt_req(mgmt_req), .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr));
  hbm_mgmt_station stn (.mdio_line(mdio_line), .mdc(mdc),
    .mdio_bit(s_bit), .mdio_oe_n(s_oe_n));

  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one host cycle; sc/sq deselect or disqualify it
  task automatic acc(input hbm_tb_row_t r, input logic sc,
                     input logic sq);
    logic sb;
    sb = sc | sq;
    @(negedge mclk);
    {mode, cs_n, aen, pse} = {r.m, sc, sq, ~sq};
    {bsel, haddr, wsel, hdin} = {r.bsel, r.ad, r.wsel, 16'hC3A5};
    p = np;
    {rd_n, wr_n} = {r.wr, ~r.wr};
    repeat (8) @(negedge mclk);
    if (sb)
      `CHK("standby oe_n", 2'h3, oe_n)
    if (!sb && !r.wr)
      `CHK("read lanes", r.exp & r.msk, hdout & r.msk)
    if (!sb && !r.wr)
      `CHK("read oe_n", 2'h0, oe_n)
    if (!sb)
      `CHK("lanes used", r.be, acc_req.be)
    {rd_n, wr_n} = 2'h3;
    if (r.wr && !sb) begin
      for (int i = 0; i < 8 && acc_wr !== 1'h1; i++)
        @(negedge mclk);
      `CHK("write pulse", 1'h1, acc_wr)
      if (acc_wr !== 1'h1)
        complete_run();
      `CHK("write data", r.exp, acc_req.wdata & r.msk)
    end
    repeat (5) @(negedge mclk);
    `CHK("release oe_n", 2'h3, oe_n)
    if (sb)
      `CHK("standby pulses", p, np)
    if (!sb)
      `CHK("access pulses", p + 1, np)
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {mclk, rst, mode, cs_n, aen, pse, rd_n, wr_n} = 9'h0D7;
    {bsel, haddr, wsel, hdin} = '0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (12) @(negedge mclk);
    rst = 1'h0;
    repeat (4) @(negedge mclk);
    `CHK("reset oe_n", 2'h3, oe_n)
    `CHK("reset mdio_oe_n", 1'h1, mdio_oe_n)
    foreach (ROWS[i])
      acc(ROWS[i], 1'h0, 1'h0);
    // deselected, aen high, program store low: all standby
    acc(ROWS[13], 1'h1, 1'h0);
    acc(ROWS[0], 1'h1, 1'h0);
    acc(ROWS[0], 1'h0, 1'h1);
    acc(ROWS[7], 1'h0, 1'h1);
    acc(ROWS[14], 1'h0, 1'h1);
    // frames run back to back with no preamble
    foreach (FRMS[i]) begin
      p = np;
      stn.frame(FRMS[i].op, FRMS[i].pa, FRMS[i].ra, FRMS[i].wd, got);
      repeat (8) @(negedge mclk);
      `CHK("frame line", FRMS[i].rd, got)
      `CHK("frame pulses", p + FRMS[i].pl, np)
      `CHK("idle mdio_oe_n", 1'h1, mdio_oe_n)
      if (i == 0)
        `CHK("mgmt write", 21'h1F8001, mgmt_req)
    end
    // reset in mid-read: lanes let go at once and stay off after release
    @(negedge mclk);
    {mode, cs_n, aen, pse} = {2'h0, 1'h0, 1'h0, 1'h1};
    {bsel, haddr, rd_n, wr_n} = {1'h0, 5'h03, 1'h0, 1'h1};
    repeat (6) @(negedge mclk);
    `CHK("read before reset", 2'h0, oe_n)
    rst = 1'h1;
    @(negedge mclk);
    `CHK("oe_n in reset", 2'h3, oe_n)
    {rd_n, wr_n} = 2'h3;
    p = np;
    @(negedge mclk);
    rst = 1'h0;
    repeat (4) @(negedge mclk);
    `CHK("oe_n after reset", 2'h3, oe_n)
    `CHK("pulses after reset", p, np)
    complete_run();
  end
endmodule
